// ==== rtl/iapfc_defs.svh ====
`ifndef IAPFC_DEFS_SVH
`define IAPFC_DEFS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define IAPFC_OFF_CTL      8'h00
`define IAPFC_OFF_KEY      8'h04
`define IAPFC_OFF_BCLR     8'h08
`define IAPFC_OFF_DATA     8'h10
`define IAPFC_DATA_STRIDE  8'h04

// ****************************************
// main control and buffer clear field positions
// ****************************************
`define IAPFC_B_STATUS     7
`define IAPFC_B_MODE_HI    6
`define IAPFC_B_MODE_LO    4
`define IAPFC_B_UNLOCK     3
`define IAPFC_B_WRINIT     2
`define IAPFC_B_RDEN       1
`define IAPFC_B_RDINIT     0
`define IAPFC_B_BCLR       0

// ****************************************
// reset values and key
// ****************************************
`define IAPFC_RST_BYTE     8'h00
`define IAPFC_RESET_KEY    8'h55

// ****************************************
// unlock pattern, per word low byte then high byte
// ****************************************
`define IAPFC_PAT_W1L      8'h00
`define IAPFC_PAT_W1H      8'h04
`define IAPFC_PAT_W2L      8'h0d
`define IAPFC_PAT_W2H      8'h09
`define IAPFC_PAT_W3L      8'hc3
`define IAPFC_PAT_W3H      8'h40

// ****************************************
// timing
// ****************************************
`define IAPFC_CLK_NS       20
`define IAPFC_EW_TIME_NS   2200000
`define IAPFC_UNL_TIME_NS  20480
`define IAPFC_RD_TIME_NS   80
`define IAPFC_CLR_TIME_NS  40
`define IAPFC_TMR_W        17

`endif

// ==== rtl/iapfc_pkg.sv ====
package iapfc_pkg;

	// operation mode field codes
	typedef enum logic [2:0]
	{
		IAPFC_MODE_WRITE  = 3'h0,
		IAPFC_MODE_ERASE  = 3'h1,
		IAPFC_MODE_READ   = 3'h3,
		IAPFC_MODE_UNLOCK = 3'h6
	} iapfc_mode_t;

	// running operation
	typedef enum logic [1:0]
	{
		IAPFC_OP_IDLE = 2'b00,
		IAPFC_OP_EW   = 2'b01,
		IAPFC_OP_RD   = 2'b10,
		IAPFC_OP_CLR  = 2'b11
	} iapfc_op_t;

	// main control register
	typedef struct packed
	{
		logic       status;
		logic [2:0] mode;
		logic       unlock_trig;
		logic       write_init;
		logic       read_en;
		logic       read_init;
	} iapfc_ctl_t;

	// strobes towards the flash array and cpu
	typedef struct packed
	{
		logic erase;
		logic write;
		logic read;
		logic bclr;
		logic stall;
	} iapfc_flash_t;

endpackage

// ==== rtl/iapfc_timer.sv ====
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// one-shot countdown, done pulses on last cycle
// ****************************************
module iapfc_timer #(
	parameter int W = 17
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	output logic              running,
	output logic              done
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;

	// reload wins over counting
	always_comb
	begin
		cnt_d = cnt_q;
		if (load)
			cnt_d = load_val;
		else if (cnt_q != '0)
			cnt_d = cnt_q - 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end

	assign running = (cnt_q != '0);
	assign done    = (cnt_q == {{(W-1){1'b0}}, 1'b1}) && !load;
endmodule

`default_nettype wire

// ==== rtl/iapfc_top.sv ====
// Summary of operation
// R1 - software may clear status, never set it
// R2 - status set by hardware on unlock success
// R3 - mode field: write, erase, read, unlock
// R4 - software unlocks before erase or write
// R5 - unlock trigger starts timer, cleared at expiry
// R6 - software loads pattern before timer expires
// R7 - write initiate runs erase/write, self-clears
// R8 - reads only while read enable high
// R9 - read initiate runs read, self-clears
// R10 - never set three initiate bits together
// R11 - cpu stalled while an operation runs; code stalls on erase/write and read only, not buffer clear
// R12 - software waits for completion before next
// R13 - slow clock stable before erase/write
// R14 - key 55h resets whole chip
// R15 - buffer clear bit self-clears when done
// R16 - buffer clear upper bits read zero
// R17 - data words readable writable byte pairs
// R18 - unlock pattern bytes fixed
// R19 - erase/write lasts 2.2 ms
// R20 - locked or reserved mode modifies nothing
// R21 - status set only on match during timer
//
// The address map and the AHB-Lite slave port are this design's own decisions.
`include "iapfc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module iapfc_top #(
	parameter int EW_CYCLES  = `IAPFC_EW_TIME_NS / `IAPFC_CLK_NS,
	parameter int UNL_CYCLES = `IAPFC_UNL_TIME_NS / `IAPFC_CLK_NS,
	parameter int RD_CYCLES  = `IAPFC_RD_TIME_NS / `IAPFC_CLK_NS,
	parameter int CLR_CYCLES = `IAPFC_CLR_TIME_NS / `IAPFC_CLK_NS
) (
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	output logic             CPU_STALL,
	output logic             CHIP_RESET,
	output logic             FLASH_ERASE,
	output logic             FLASH_WRITE,
	output logic             FLASH_READ,
	output logic             FLASH_BUF_CLEAR
);
	import iapfc_pkg::*;

	localparam int TW = `IAPFC_TMR_W;
	localparam logic [7:0] PAT [6] = '{`IAPFC_PAT_W1L, `IAPFC_PAT_W1H,
		`IAPFC_PAT_W2L, `IAPFC_PAT_W2H, `IAPFC_PAT_W3L, `IAPFC_PAT_W3H};

	// ****************************************
	// ahb-lite slave front end
	// ****************************************
	logic        wr_pend_q, wr_pend_d;
	logic        rd_pend_q, rd_pend_d;
	logic [7:0]  addr_q, addr_d;
	logic        hit_q, hit_d;
	logic        hready_q, hready_d;
	logic [31:0] hrdata_q, hrdata_d;
	logic        accept;

	// reads take one wait state so a write just ahead is visible
	assign accept = HSEL && HTRANS[1] && HREADY;

	always_comb
	begin
		wr_pend_d = 1'b0;
		rd_pend_d = 1'b0;
		addr_d    = addr_q;
		hit_d     = hit_q;
		hready_d  = 1'b1;
		if (accept)
		begin
			addr_d    = HADDR[7:0];
			hit_d     = (HADDR[31:8] == 24'h000000) && (HADDR[1:0] == 2'h0);
			wr_pend_d = HWRITE;
			rd_pend_d = !HWRITE;
			hready_d  = HWRITE;
		end
	end

	// ****************************************
	// register decode
	// ****************************************
	logic       wr_ctl, wr_key, wr_bclr;
	logic [5:0] wr_dat;
	logic [7:0] wd;

	assign wd      = HWDATA[7:0];
	assign wr_ctl  = wr_pend_q && hit_q && (addr_q == `IAPFC_OFF_CTL);
	assign wr_key  = wr_pend_q && hit_q && (addr_q == `IAPFC_OFF_KEY);
	assign wr_bclr = wr_pend_q && hit_q && (addr_q == `IAPFC_OFF_BCLR);

	// ****************************************
	// data word bytes and pattern compare
	// ****************************************
	logic [7:0] dat_q [6];
	logic [7:0] dat_d [6];
	logic [5:0] pat_ok;

	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++)
		begin : g_dat
			assign wr_dat[gi] = wr_pend_q && hit_q && (addr_q ==
				8'(`IAPFC_OFF_DATA + gi * `IAPFC_DATA_STRIDE));
			assign dat_d[gi]  = wr_dat[gi] ? wd : dat_q[gi]; // [R17]
			assign pat_ok[gi] = (dat_q[gi] == PAT[gi]);      // [R18]
			always_ff @(posedge CLK)
			begin
				if (RST)
					dat_q[gi] <= `IAPFC_RST_BYTE;
				else
					dat_q[gi] <= dat_d[gi];
			end
		end
	endgenerate

	// ****************************************
	// control state
	// ****************************************
	iapfc_ctl_t   ctl_q, ctl_d;
	iapfc_op_t    op_q, op_d;
	logic [7:0]   key_q, key_d;
	logic         bclr_q, bclr_d;
	logic         rstk_q, rstk_d;
	iapfc_flash_t fl_q, fl_d;
	logic         unl_load, unl_run, unl_done;
	logic         op_load, op_done;
	logic [TW-1:0] op_len;
	logic         set_cond, all_three;
	logic [2:0]   nmode;

	assign nmode     = wd[`IAPFC_B_MODE_HI:`IAPFC_B_MODE_LO];
	assign all_three = wd[`IAPFC_B_WRINIT] && wd[`IAPFC_B_RDEN] && wd[`IAPFC_B_RDINIT];
	// only a full match inside the window in unlock mode counts
	assign set_cond  = ctl_q.unlock_trig && unl_run && (&pat_ok) &&
		(ctl_q.mode == IAPFC_MODE_UNLOCK); // [R2] [R21]

	// software writes, hardware completions, operation launch
	always_comb
	begin
		ctl_d    = ctl_q;
		op_d     = op_q;
		key_d    = key_q;
		bclr_d   = bclr_q;
		rstk_d   = 1'b0;
		unl_load = 1'b0;
		op_load  = 1'b0;
		op_len   = TW'(EW_CYCLES);
		// completions first so a new launch cannot be lost
		if (op_done)
		begin
			op_d             = IAPFC_OP_IDLE;
			ctl_d.write_init = 1'b0; // [R7]
			ctl_d.read_init  = 1'b0; // [R9]
			bclr_d           = 1'b0; // [R15]
		end
		if (unl_done)
			ctl_d.unlock_trig = 1'b0; // [R5]
		if (wr_ctl)
		begin
			ctl_d.mode    = nmode; // [R3]
			ctl_d.read_en = wd[`IAPFC_B_RDEN];
			if (!wd[`IAPFC_B_STATUS])
				ctl_d.status = 1'b0; // [R1]
			if (wd[`IAPFC_B_UNLOCK] && !ctl_q.unlock_trig)
			begin
				ctl_d.unlock_trig = 1'b1;
				unl_load          = 1'b1; // [R5]
			end
			// triple set is refused, no erase/write or read starts
			if (op_q == IAPFC_OP_IDLE && !all_three) // [R10]
			begin
				if (wd[`IAPFC_B_WRINIT] && ctl_d.status &&
					(nmode == IAPFC_MODE_WRITE || nmode == IAPFC_MODE_ERASE)) // [R20]
				begin
					ctl_d.write_init = 1'b1; // [R7]
					op_d             = IAPFC_OP_EW;
					op_load          = 1'b1;
					op_len           = TW'(EW_CYCLES); // [R19]
				end
				else if (wd[`IAPFC_B_RDINIT] && wd[`IAPFC_B_RDEN] &&
					nmode == IAPFC_MODE_READ) // [R8]
				begin
					ctl_d.read_init = 1'b1; // [R9]
					op_d            = IAPFC_OP_RD;
					op_load         = 1'b1;
					op_len          = TW'(RD_CYCLES);
				end
			end
		end
		if (wr_bclr && wd[`IAPFC_B_BCLR] && op_q == IAPFC_OP_IDLE)
		begin
			bclr_d  = 1'b1; // [R15]
			op_d    = IAPFC_OP_CLR;
			op_load = 1'b1;
			op_len  = TW'(CLR_CYCLES);
		end
		if (wr_key)
		begin
			key_d  = wd;
			rstk_d = (wd == `IAPFC_RESET_KEY); // [R14]
		end
		// hardware set beats a same-cycle software clear
		if (set_cond)
			ctl_d.status = 1'b1; // [R2] [R21]
	end

	// flash strobes and cpu hold follow the running op
	always_comb
	begin
		fl_d.erase = (op_d == IAPFC_OP_EW) && (ctl_d.mode == IAPFC_MODE_ERASE);
		fl_d.write = (op_d == IAPFC_OP_EW) && (ctl_d.mode == IAPFC_MODE_WRITE);
		fl_d.read  = (op_d == IAPFC_OP_RD);
		fl_d.bclr  = (op_d == IAPFC_OP_CLR);
		fl_d.stall = (op_d == IAPFC_OP_EW) || (op_d == IAPFC_OP_RD); // [R11]
	end

	// read mux, captured in the wait state
	always_comb
	begin
		hrdata_d = hrdata_q;
		if (rd_pend_q)
		begin
			hrdata_d = 32'h00000000;
			if (hit_q)
			begin
				if (addr_q == `IAPFC_OFF_CTL)
					hrdata_d[7:0] = ctl_q;
				else if (addr_q == `IAPFC_OFF_KEY)
					hrdata_d[7:0] = key_q;
				else if (addr_q == `IAPFC_OFF_BCLR)
					hrdata_d[`IAPFC_B_BCLR] = bclr_q; // [R16]
				for (int i = 0; i < 6; i++)
					if (addr_q == 8'(`IAPFC_OFF_DATA + i * `IAPFC_DATA_STRIDE))
						hrdata_d[7:0] = dat_q[i]; // [R17]
			end
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q    <= 8'h00;
			hit_q     <= 1'b0;
			hready_q  <= 1'b1;
			hrdata_q  <= 32'h00000000;
			ctl_q     <= '0;
			op_q      <= IAPFC_OP_IDLE;
			key_q     <= `IAPFC_RST_BYTE;
			bclr_q    <= 1'b0;
			rstk_q    <= 1'b0;
			fl_q      <= '0;
		end
		else
		begin
			wr_pend_q <= wr_pend_d;
			rd_pend_q <= rd_pend_d;
			addr_q    <= addr_d;
			hit_q     <= hit_d;
			hready_q  <= hready_d;
			hrdata_q  <= hrdata_d;
			ctl_q     <= ctl_d;
			op_q      <= op_d;
			key_q     <= key_d;
			bclr_q    <= bclr_d;
			rstk_q    <= rstk_d;
			fl_q      <= fl_d;
		end
	end

	// ****************************************
	// timers
	// ****************************************
	iapfc_timer #(.W(TW)) u_unl_tmr (
		.clk      (CLK),
		.rst      (RST),
		.load     (unl_load),
		.load_val (TW'(UNL_CYCLES)),
		.running  (unl_run),
		.done     (unl_done)
	);

	iapfc_timer #(.W(TW)) u_op_tmr (
		.clk      (CLK),
		.rst      (RST),
		.load     (op_load),
		.load_val (op_len),
		.running  (),
		.done     (op_done)
	);

	assign HRDATA          = hrdata_q;
	assign HREADYOUT       = hready_q;
	assign HRESP           = 1'b0;
	assign CPU_STALL       = fl_q.stall;
	assign CHIP_RESET      = rstk_q;
	assign FLASH_ERASE     = fl_q.erase;
	assign FLASH_WRITE     = fl_q.write;
	assign FLASH_READ      = fl_q.read;
	assign FLASH_BUF_CLEAR = fl_q.bclr;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	// helper: length of trigger high phases
	logic [TW-1:0] unl_len_q, ew_len_q;
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			unl_len_q <= '0;
			ew_len_q  <= '0;
		end
		else
		begin
			unl_len_q <= ctl_q.unlock_trig ? unl_len_q + 1'b1 : '0;
			ew_len_q  <= ctl_q.write_init ? ew_len_q + 1'b1 : '0;
		end
	end

	status_no_set_a: assert property (!ctl_q.status && !set_cond |=> !ctl_q.status) // [R1]
		else $error("status rose without unlock");
	status_set_a: assert property (set_cond |=> ctl_q.status) // [R2] [R21]
		else $error("status missed unlock match");
	mode_field_a: assert property (wr_ctl |=> ctl_q.mode == $past(nmode)) // [R3]
		else $error("mode field not stored");
	unlock_len_a: assert property ($fell(ctl_q.unlock_trig) |-> unl_len_q == TW'(UNL_CYCLES)) // [R5]
		else $error("unlock window length wrong");
	ew_len_a: assert property ($fell(ctl_q.write_init) |-> ew_len_q == TW'(EW_CYCLES)) // [R7] [R19]
		else $error("erase/write length wrong");
	read_gate_a: assert property ($rose(ctl_q.read_init) |-> ctl_q.read_en) // [R8]
		else $error("read started while disabled");
	read_done_a: assert property ($rose(ctl_q.read_init) |-> ##[1:1000] !ctl_q.read_init) // [R9]
		else $error("read never completed");
	triple_a: assert property (wr_ctl && all_three |=> !$rose(ctl_q.write_init) && !$rose(ctl_q.read_init)) // [R10]
		else $error("triple initiate accepted");
	cpu_stall_a: assert property ($rose(ctl_q.write_init) |-> CPU_STALL && !$past(CPU_STALL)) // [R11]
		else $error("cpu not stalled on erase/write");
	chip_reset_a: assert property (wr_key && wd == `IAPFC_RESET_KEY |=> CHIP_RESET ##1 !CHIP_RESET) // [R14]
		else $error("chip reset pulse wrong");
	bclr_read_a: assert property (rd_pend_q && hit_q && addr_q == `IAPFC_OFF_BCLR |=> HRDATA[31:1] == '0) // [R16]
		else $error("buffer clear upper bits set");
	locked_a: assert property ($rose(ctl_q.write_init) |-> $past(ctl_q.status)) // [R20]
		else $error("erase/write while locked");

	unlock_c: cover property ($rose(ctl_q.status));
	ew_c: cover property ($fell(ctl_q.write_init));
	read_c: cover property ($fell(ctl_q.read_init));
	bclr_c: cover property ($fell(bclr_q));
endmodule

`default_nettype wire

// ==== bench/iapfc_flash_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// flash array stand-in
// ****************************************
module iapfc_flash_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       erase_s,
	input  wire logic       write_s,
	input  wire logic       read_s,
	output logic      [7:0] mod_count,
	output logic      [7:0] rd_count
);
	logic busy_q;

	// count starts only, a level strobe is one operation
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			mod_count <= 8'h00;
			rd_count  <= 8'h00;
			busy_q    <= 1'b0;
		end
		else
		begin
			busy_q <= erase_s | write_s | read_s;
			if ((erase_s | write_s) && !busy_q)
				mod_count <= mod_count + 8'h01;
			if (read_s && !busy_q)
				rd_count <= rd_count + 8'h01;
		end
	end
endmodule

`default_nettype wire

// ==== bench/tb_iap_flash_control.sv ====
`include "iapfc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// register level bench
// ****************************************
module tb_iap_flash_control;
	// short counts keep the run brief
	localparam int EW  = 20;
	localparam int UNL = 64;
	localparam int RD  = 4;
	localparam int CLR = 2;

	logic        clk;
	logic        rst;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hready;
	logic        hresp;
	logic        stall;
	logic        chip_rst;
	logic [3:0]  fl;
	logic [7:0]  mods;
	logic [7:0]  rds;
	logic [7:0]  pat [6];
	int          err_total;
	int          checks_done;
	int          cyc;

	iapfc_top #(
		.EW_CYCLES (EW),
		.UNL_CYCLES(UNL),
		.RD_CYCLES (RD),
		.CLR_CYCLES(CLR)
	) i_dut (
		.CLK            (clk),
		.RST            (rst),
		.HSEL           (hsel),
		.HADDR          (haddr),
		.HTRANS         (htrans),
		.HWRITE         (hwrite),
		.HSIZE          (3'h2),
		.HWDATA         (hwdata),
		.HREADY         (hready),
		.HRDATA         (hrdata),
		.HREADYOUT      (hready),
		.HRESP          (hresp),
		.CPU_STALL      (stall),
		.CHIP_RESET     (chip_rst),
		.FLASH_ERASE    (fl[3]),
		.FLASH_WRITE    (fl[2]),
		.FLASH_READ     (fl[1]),
		.FLASH_BUF_CLEAR(fl[0])
	);

	iapfc_flash_model i_array (
		.clk      (clk),
		.rst      (rst),
		.erase_s  (fl[3]),
		.write_s  (fl[2]),
		.read_s   (fl[1]),
		.mod_count(mods),
		.rd_count (rds)
	);

	initial
	begin
		clk = 1'b0;
		forever
			#10 clk = ~clk;
	end

	// hang guard, real run is far shorter
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			err_total = err_total + 1;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		if (err_total == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done = checks_done + 1;
		if (seen !== exp)
		begin
			err_total = err_total + 1;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// single ahb transfer, waits on hready in both phases
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		int waits;
		waits = 0;
		@(posedge clk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {24'h0, a};
		@(posedge clk);
		while (!hready)
			@(posedge clk);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		@(posedge clk);
		// writes finish at once, reads insert one wait state
		while (!hready)
		begin
			waits++;
			@(posedge clk);
		end
		chk(32'(waits), w ? 32'h0 : 32'h1);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		chk(hrdata, {24'h0, exp});
		chk(hresp, 1'b0);
	endtask

	// data words at 0x10..0x24; bad spoils the last byte
	task automatic load(input logic [7:0] bad);
		for (int i = 0; i < 6; i++)
			bus(1'b1, 8'(`IAPFC_OFF_DATA + 4 * i), pat[i] ^ ((i == 5) ? bad : 8'h00));
	endtask

	// write, check strobes and their length, then read back
	task automatic run_op(input logic [7:0] a, input logic [7:0] v, input logic [3:0] s,
		input int n, input logic [7:0] rb);
		int k;
		k = 0;
		bus(1'b1, a, v);
		#1;
		chk(fl, s);
		chk(stall, |s[3:1]);
		while ((|fl) && k < 1000)
		begin
			k++;
			@(posedge clk);
			#1;
		end
		chk(32'(k), (s == 4'h0) ? 32'h0 : 32'(n));
		chk(stall, 1'b0);
		rd(a, rb);
	endtask

	initial
	begin
		rst         = 1'b1;
		hsel        = 1'b0;
		haddr       = 32'h0;
		htrans      = 2'h0;
		hwrite      = 1'b0;
		hwdata      = 32'h0;
		err_total   = 0;
		checks_done = 0;
		cyc         = 0;
		pat = '{`IAPFC_PAT_W1L, `IAPFC_PAT_W1H, `IAPFC_PAT_W2L,
			`IAPFC_PAT_W2H, `IAPFC_PAT_W3L, `IAPFC_PAT_W3H};
		repeat (10)
			@(posedge clk);
		rst <= 1'b0;
		// reset values, then data pairs and an unmapped word
		for (int i = 0; i < 10; i++)
			rd(8'(i * 4 + ((i < 3) ? 0 : 4)), 8'h00);
		for (int i = 3; i < 10; i++)
			bus(1'b1, 8'(i * 4 + 4), 8'(8'ha0 + i));
		for (int i = 3; i < 10; i++)
			rd(8'(i * 4 + 4), (i < 9) ? 8'(8'ha0 + i) : 8'h00);
		// buffer clear and chip reset key
		run_op(`IAPFC_OFF_BCLR, 8'hff, 4'h1, CLR, 8'h00);
		bus(1'b1, `IAPFC_OFF_KEY, 8'h54);
		#1;
		chk(chip_rst, 1'b0);
		bus(1'b1, `IAPFC_OFF_KEY, 8'h55);
		#1;
		chk(chip_rst, 1'b1);
		@(posedge clk);
		#1;
		chk(chip_rst, 1'b0);
		rd(`IAPFC_OFF_KEY, 8'h55);
		// locked erase attempt, status cannot be set by software
		run_op(`IAPFC_OFF_CTL, 8'h94, 4'h0, EW, 8'h10);
		// wrong last byte: window expires without success
		bus(1'b1, `IAPFC_OFF_CTL, 8'h68);
		load(8'h01);
		repeat (UNL)
			@(posedge clk);
		rd(`IAPFC_OFF_CTL, 8'h60);
		// right bytes outside unlock mode
		bus(1'b1, `IAPFC_OFF_CTL, 8'h08);
		load(8'h00);
		rd(`IAPFC_OFF_CTL, 8'h08);
		repeat (UNL)
			@(posedge clk);
		rd(`IAPFC_OFF_CTL, 8'h00);
		// proper unlock sequence
		bus(1'b1, `IAPFC_OFF_CTL, 8'h68);
		load(8'h00);
		rd(`IAPFC_OFF_CTL, 8'he8);
		repeat (UNL)
			@(posedge clk);
		rd(`IAPFC_OFF_CTL, 8'he0);
		// every mode code with write initiate, only 000 and 001 run
		// one bench clock, so the slow clock counts as settled
		for (int m = 0; m < 8; m++)
			run_op(`IAPFC_OFF_CTL, {1'b1, 3'(m), 4'h4},
				(m == 0) ? 4'h4 : ((m == 1) ? 4'h8 : 4'h0), EW, {1'b1, 3'(m), 4'h0});
		run_op(`IAPFC_OFF_CTL, 8'hb3, 4'h2, RD, 8'hb2);
		run_op(`IAPFC_OFF_CTL, 8'hb1, 4'h0, RD, 8'hb0);
		run_op(`IAPFC_OFF_CTL, 8'hb7, 4'h0, RD, 8'hb2);
		// clearing status locks erase and write again
		run_op(`IAPFC_OFF_CTL, 8'h30, 4'h0, RD, 8'h30);
		run_op(`IAPFC_OFF_CTL, 8'h84, 4'h0, EW, 8'h00);
		chk(mods, 8'h02);
		chk(rds, 8'h01);
		tally_and_finish();
	end
endmodule

`default_nettype wire
